// >>> gpio_port_params.svh
// Offsets, field masks, reset values and bus codes for the GPIO port block.
// Assumes a byte-addressed AXI4-Lite map with one 32-bit word per register.
//
// How it works
// [R1] Pin-value writes land in the output latch
// [R2] Pin-value reads return sampled pin levels
// [R3] Direction one turns the pin driver off
// [R4] Direction zero drives the latch onto pin
// [R5] Pin-value write is read-modify-write of pins
// [R6] Direction still drives pins in analog mode
// [R7] Analog-selected pins read zero digitally
// [R8] Analog select never gates digital output
// [R9] Implemented analog bits reset to one
// [R10] Port A analog bits five, three..zero
// [R11] Port B analog bits five..zero only
// [R12] Highest enabled output function owns pin
// [R13] Port B function priority order per pin
// [R14] Input functions stay live on outputs
// [R15] Port B direction resets to all inputs
// [R16] Latch read returns all eight latch bits
// [R17] Software sets direction input for analog
// [R18] Software clears analog bit for digital
// [R19] Pull-up off whenever pin is an output
// [R20] Latch and pin value survive warm resets
`ifndef GPIO_PORT_PARAMS_SVH
`define GPIO_PORT_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_PORT_A_OUTPUT_LATCH 8'h00
`define OFS_PORT_A_ANALOG_SELECT 8'h04
`define OFS_PORT_B_PIN_VALUE 8'h08
`define OFS_PORT_B_DIRECTION 8'h0C
`define OFS_PORT_B_OUTPUT_LATCH 8'h10
`define OFS_PORT_B_ANALOG_SELECT 8'h14
`define OFS_PORT_B_PULLUP 8'h18
`define OFS_PULLUP_CONTROL 8'h1C

// ----------------------------------------
// Field masks and reset values
// ----------------------------------------
`define PORT_A_ANALOG_MASK 8'h2F
`define PORT_B_ANALOG_MASK 8'h3F
`define PORT_B_DIRECTION_RESET 8'hFF
`define PORT_B_PULLUP_RESET 8'hFF
`define GLOBAL_PULLUP_DISABLE_BIT 0
`define GLOBAL_PULLUP_DISABLE_RESET 1'b1

// ----------------------------------------
// Pin function slots and bus codes
// ----------------------------------------
`define FUNC_SLOTS 4
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// >>> gpio_port_pkg.sv
// Types shared by the GPIO port block: bus carriers and pin function requests.
// Assumes the parameter header is on the include path.
`default_nettype none

package gpio_port_pkg;
	`include "gpio_port_params.svh"

	// ----------------------------------------
	// AXI4-Lite carriers
	// ----------------------------------------
	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} axil_req_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axil_rsp_type;

	// One register write handed from the bus slave to the register file
	typedef struct packed {
		logic en;
		logic [7:0] addr;
		logic [7:0] data;
		logic strb;
	} reg_wr_type;

	// One peripheral's claim on a pin
	typedef struct packed {
		logic en;
		logic oe;
		logic out;
	} pin_func_type;

	// Mapped word addresses answer OKAY, everything else SLVERR
	function automatic logic addr_mapped(input logic [7:0] addr);
		case (addr)
			`OFS_PORT_A_OUTPUT_LATCH, `OFS_PORT_A_ANALOG_SELECT, `OFS_PORT_B_PIN_VALUE,
			`OFS_PORT_B_DIRECTION, `OFS_PORT_B_OUTPUT_LATCH, `OFS_PORT_B_ANALOG_SELECT,
			`OFS_PORT_B_PULLUP, `OFS_PULLUP_CONTROL: addr_mapped = 1'b1;
			default: addr_mapped = 1'b0;
		endcase
	endfunction : addr_mapped
endpackage : gpio_port_pkg

`default_nettype wire

// >>> pin_priority_mux.sv
// Per-pin output arbiter: the highest-ranked enabled function owns the driver.
// Assumes slot 0 is the highest rank and the port bit is the fallback.
`timescale 1ns/1ps
`default_nettype none

module pin_priority_mux #(
	parameter int SLOTS = 4
) (
	input wire gpio_port_pkg::pin_func_type [3:0] func,
	input wire logic port_oe,
	input wire logic port_out,
	output logic oe,
	output logic out
);
	import gpio_port_pkg::*;

	// Walk from lowest rank upward so the last hit is the highest rank
	always_comb begin
		oe = port_oe;
		out = port_out;
		for (int s = SLOTS - 1; s >= 0; s--) begin
			if (func[s].en) begin // R12
				oe = func[s].oe;
				out = func[s].out;
			end
		end
	end
endmodule : pin_priority_mux

`default_nettype wire

// >>> axil_reg_slave.sv
// AXI4-Lite slave front end: takes address and data in either order, then
// issues one register write pulse; reads answer one cycle after the address.
// Assumes the register file supplies read data combinationally from araddr.
`timescale 1ns/1ps
`default_nettype none

module axil_reg_slave (
	input wire logic aclk,
	input wire logic aresetn,
	input wire gpio_port_pkg::axil_req_type req,
	input wire logic [31:0] rd_data,
	output gpio_port_pkg::axil_rsp_type rsp,
	output gpio_port_pkg::reg_wr_type wr
);
	import gpio_port_pkg::*;

	logic aw_have_q;
	logic w_have_q;
	logic [7:0] awaddr_q;
	logic [7:0] wdata_q;
	logic wstrb_q;
	logic awready_q;
	logic wready_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic arready_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	// ----------------------------------------
	// Write channels
	// ----------------------------------------
	// Ready drops once a beat is held, so each channel holds at most one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 8'h00;
			wstrb_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `RESP_OKAY;
			wr <= '0;
		end else begin
			wr.en <= 1'b0;
			if (req.awvalid && awready_q) begin
				awready_q <= 1'b0;
				aw_have_q <= 1'b1;
				awaddr_q <= req.awaddr;
			end
			if (req.wvalid && wready_q) begin
				wready_q <= 1'b0;
				w_have_q <= 1'b1;
				wdata_q <= req.wdata[7:0];
				wstrb_q <= req.wstrb[0];
			end
			if (aw_have_q && w_have_q) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				wr.en <= 1'b1;
				wr.addr <= awaddr_q;
				wr.data <= wdata_q;
				wr.strb <= wstrb_q;
				bvalid_q <= 1'b1;
				bresp_q <= addr_mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (bvalid_q && req.bready) begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Read channels
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `RESP_OKAY;
		end else if (req.arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_data;
			rresp_q <= addr_mapped(req.araddr) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rvalid_q && req.rready) begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	// Fields gathered in one place so the carrier has a single driver
	always_comb begin
		rsp.awready = awready_q;
		rsp.wready = wready_q;
		rsp.bvalid = bvalid_q;
		rsp.bresp = bresp_q;
		rsp.arready = arready_q;
		rsp.rvalid = rvalid_q;
		rsp.rdata = rdata_q;
		rsp.rresp = rresp_q;
	end
endmodule : axil_reg_slave

`default_nettype wire

// >>> gpio_port_latch_analog_select.sv
// Port A latch and analog select, and the full port B: pin sampling, output
// latch, direction, analog select, pull-up gating and function priority.
// Assumes pins and peripheral requests are synchronous to aclk and that the
// pad ring resolves pin_oe/pin_out into the wire level.
`timescale 1ns/1ps
`default_nettype none

module gpio_port_latch_analog_select (
	input wire logic aclk,
	input wire logic aresetn,
	input wire gpio_port_pkg::axil_req_type axil_req,
	output gpio_port_pkg::axil_rsp_type axil_rsp,
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	input wire gpio_port_pkg::pin_func_type [7:0][3:0] func_req,
	output logic [7:0] pullup_en,
	output logic [7:0] digital_in,
	output logic [7:0] port_b_analog_bit,
	output logic [7:0] port_a_output_latch,
	output logic [7:0] port_a_analog_bit
);
	import gpio_port_pkg::*;
	`include "gpio_port_params.svh"

	reg_wr_type wr;
	logic [31:0] rd_data;
	logic [7:0] port_a_output_latch_q;
	logic [7:0] port_a_analog_select_q;
	logic [7:0] port_b_direction_q;
	logic [7:0] port_b_output_latch_q;
	logic [7:0] port_b_analog_select_q;
	logic [7:0] port_b_pullup_q;
	logic global_pullup_disable_q;
	logic [7:0] pin_sample_q;
	logic [7:0] digital_read;
	logic [7:0] mux_oe;
	logic [7:0] mux_out;

	// ----------------------------------------
	// Bus front end
	// ----------------------------------------
	axil_reg_slave u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.req(axil_req),
		.rd_data(rd_data),
		.rsp(axil_rsp),
		.wr(wr)
	);

	// Write decode helpers
	function automatic logic hit(input reg_wr_type w, input logic [7:0] ofs);
		hit = w.en && w.strb && (w.addr == ofs);
	endfunction : hit

	// ----------------------------------------
	// Pin sampling and digital read path
	// ----------------------------------------
	// No reset: pin value is undefined at power up and kept over warm resets
	always_ff @(posedge aclk) begin
		pin_sample_q <= pin_in; // R2 R20
	end

	// Analog-selected pins have their input buffer off and read as zero
	assign digital_read = pin_sample_q & ~port_b_analog_select_q; // R7

	// ----------------------------------------
	// Output latches
	// ----------------------------------------
	// Latches skip aresetn so contents survive every reset but power-up
	always_ff @(posedge aclk) begin
		if (hit(wr, `OFS_PORT_A_OUTPUT_LATCH)) begin
			port_a_output_latch_q <= wr.data;
		end
	end

	// A pin-value write goes to the latch, never straight to the pins.
	// Without the low byte lane the read half of the read-modify-write
	// still happens: the digital pin read, analog pins as zero, is copied into the latch.
	always_ff @(posedge aclk) begin
		if (wr.en && wr.addr == `OFS_PORT_B_PIN_VALUE) begin
			port_b_output_latch_q <= wr.strb ? wr.data : digital_read; // R1 R5
		end else if (hit(wr, `OFS_PORT_B_OUTPUT_LATCH)) begin
			port_b_output_latch_q <= wr.data;
		end
	end

	// ----------------------------------------
	// Direction and analog select
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_b_direction_q <= `PORT_B_DIRECTION_RESET; // R15
		end else if (hit(wr, `OFS_PORT_B_DIRECTION)) begin
			port_b_direction_q <= wr.data;
		end
	end

	// Unimplemented bits are masked on every write so they stay zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_a_analog_select_q <= `PORT_A_ANALOG_MASK; // R9
		end else if (hit(wr, `OFS_PORT_A_ANALOG_SELECT)) begin
			port_a_analog_select_q <= wr.data & `PORT_A_ANALOG_MASK; // R10
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_b_analog_select_q <= `PORT_B_ANALOG_MASK; // R9
		end else if (hit(wr, `OFS_PORT_B_ANALOG_SELECT)) begin
			port_b_analog_select_q <= wr.data & `PORT_B_ANALOG_MASK; // R11
		end
	end

	// ----------------------------------------
	// Weak pull-up controls
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_b_pullup_q <= `PORT_B_PULLUP_RESET;
			global_pullup_disable_q <= `GLOBAL_PULLUP_DISABLE_RESET;
		end else begin
			if (hit(wr, `OFS_PORT_B_PULLUP)) begin
				port_b_pullup_q <= wr.data;
			end
			if (hit(wr, `OFS_PULLUP_CONTROL)) begin
				global_pullup_disable_q <= wr.data[`GLOBAL_PULLUP_DISABLE_BIT];
			end
		end
	end

	// ----------------------------------------
	// Register read mux
	// ----------------------------------------
	// Decoded from araddr directly; the slave registers the answer
	always_comb begin
		rd_data = 32'h0000_0000;
		case (axil_req.araddr)
			`OFS_PORT_A_OUTPUT_LATCH: rd_data[7:0] = port_a_output_latch_q;
			`OFS_PORT_A_ANALOG_SELECT: rd_data[7:0] = port_a_analog_select_q; // R10
			`OFS_PORT_B_PIN_VALUE: rd_data[7:0] = digital_read; // R2 R7
			`OFS_PORT_B_DIRECTION: rd_data[7:0] = port_b_direction_q;
			`OFS_PORT_B_OUTPUT_LATCH: rd_data[7:0] = port_b_output_latch_q; // R16
			`OFS_PORT_B_ANALOG_SELECT: rd_data[7:0] = port_b_analog_select_q; // R11
			`OFS_PORT_B_PULLUP: rd_data[7:0] = port_b_pullup_q;
			`OFS_PULLUP_CONTROL: rd_data[`GLOBAL_PULLUP_DISABLE_BIT] = global_pullup_disable_q;
			default: rd_data = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// Per-pin output priority
	// ----------------------------------------
	// Pins 0..3: lcd segment, analog channel, special, change interrupt.
	// Pins 4..5: lcd common, analog channel, change interrupt.
	// Pins 6..7: debug clock or data, lcd segment, change interrupt.
	// The port bit always ranks last; direction drives it whatever the
	// analog select says, so analog select never appears here.
	for (genvar p = 0; p < 8; p++) begin : g_pin
		pin_priority_mux #(
			.SLOTS(p < 4 ? `FUNC_SLOTS : `FUNC_SLOTS - 1)
		) u_mux (
			.func(func_req[p]),
			.port_oe(~port_b_direction_q[p]), // R3 R4 R6 R8
			.port_out(port_b_output_latch_q[p]),
			.oe(mux_oe[p]), // R12 R13
			.out(mux_out[p])
		);
	end

	// ----------------------------------------
	// Registered pin and peripheral outputs
	// ----------------------------------------
	// One flop stage keeps the pad drivers glitch free; costs a cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_oe <= 8'h00;
			pin_out <= 8'h00;
		end else begin
			pin_oe <= mux_oe; // R3 R4 R12
			pin_out <= mux_out & mux_oe;
		end
	end

	// Pull-up only on pins whose driver is off
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pullup_en <= 8'h00;
		end else begin
			pullup_en <= port_b_pullup_q & ~mux_oe & {8{~global_pullup_disable_q}}; // R19
		end
	end

	// Peripheral inputs keep listening even while the pin drives
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			digital_in <= 8'h00;
			port_b_analog_bit <= `PORT_B_ANALOG_MASK;
			port_a_analog_bit <= `PORT_A_ANALOG_MASK;
			port_a_output_latch <= 8'h00;
		end else begin
			digital_in <= digital_read; // R14
			port_b_analog_bit <= port_b_analog_select_q;
			port_a_analog_bit <= port_a_analog_select_q;
			port_a_output_latch <= port_a_output_latch_q;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	latch_from_pin_write_a: assert property ( // R1
		wr.en && wr.strb && wr.addr == `OFS_PORT_B_PIN_VALUE
		|=> port_b_output_latch_q == $past(wr.data)
	) else $error("pin-value write did not reach the latch");

	pin_read_value_a: assert property ( // R2
		axil_req.arvalid && axil_rsp.arready && axil_req.araddr == `OFS_PORT_B_PIN_VALUE
		|=> axil_rsp.rdata[7:0] == ($past(pin_sample_q) & ~$past(port_b_analog_select_q))
	) else $error("pin-value read did not return sampled pins");

	input_tristate_a: assert property ( // R3
		(port_b_direction_q == 8'hFF) && (func_req == '0) |=> pin_oe == 8'h00
	) else $error("input pin still driven");

	output_drive_a: assert property ( // R4
		!port_b_direction_q[0] && func_req[0] == '0
		|=> pin_oe[0] && pin_out[0] == $past(port_b_output_latch_q[0])
	) else $error("output pin not driving latch value");

	rmw_copy_a: assert property ( // R5
		wr.en && !wr.strb && wr.addr == `OFS_PORT_B_PIN_VALUE
		|=> port_b_output_latch_q == $past(digital_read)
	) else $error("read-modify-write did not copy pin levels");

	analog_reads_zero_a: assert property ( // R7
		(digital_read & port_b_analog_select_q) == 8'h00
	) else $error("analog pin read as nonzero");

	analog_drive_kept_a: assert property ( // R8
		port_b_analog_select_q[1] && !port_b_direction_q[1] && func_req[1] == '0
		|=> pin_oe[1]
	) else $error("analog select blocked the output driver");

	analog_masks_a: assert property ( // R10
		(port_a_analog_select_q & ~`PORT_A_ANALOG_MASK) == 8'h00
		&& (port_b_analog_select_q & ~`PORT_B_ANALOG_MASK) == 8'h00
	) else $error("unimplemented analog bit set");

	reset_state_a: assert property ( // R15
		$rose(aresetn) |-> port_b_direction_q == `PORT_B_DIRECTION_RESET
		&& port_a_analog_select_q == `PORT_A_ANALOG_MASK
		&& port_b_analog_select_q == `PORT_B_ANALOG_MASK
	) else $error("reset values wrong after release");

	top_priority_a: assert property ( // R13
		func_req[6][0].en && func_req[6][1].en
		|=> pin_oe[6] == $past(func_req[6][0].oe)
	) else $error("debug function lost pin to lower rank");

	pullup_output_off_a: assert property ( // R19
		mux_oe[2] |=> !pullup_en[2]
	) else $error("pull-up left on for an output pin");

	write_response_a: assert property (
		axil_rsp.bvalid && !axil_req.bready |=> axil_rsp.bvalid
	) else $error("write response dropped before taken");

	// ----------------------------------------
	// Bus, read-back, register write and pin assertions
	// ----------------------------------------
	// Readies stay low while an answer waits, so one transfer is in flight
	bus_refuse_a: assert property (
		axil_rsp.bvalid |-> !axil_rsp.awready && !axil_rsp.wready
	) else $error("write taken while response pending");

	read_refuse_a: assert property (
		axil_rsp.rvalid |-> !axil_rsp.arready
	) else $error("read taken while data pending");

	latch_read_a: assert property ( // R16
		axil_req.arvalid && axil_rsp.arready && axil_req.araddr == `OFS_PORT_B_OUTPUT_LATCH
		|=> axil_rsp.rdata == {24'h00_0000, $past(port_b_output_latch_q)}
	) else $error("latch read did not return the latch");

	analog_a_read_a: assert property ( // R10
		axil_req.arvalid && axil_rsp.arready && axil_req.araddr == `OFS_PORT_A_ANALOG_SELECT
		|=> (axil_rsp.rdata & ~{24'h00_0000, `PORT_A_ANALOG_MASK}) == 32'h0000_0000
	) else $error("port A analog read shows unused bits");

	analog_b_read_a: assert property ( // R11
		axil_req.arvalid && axil_rsp.arready && axil_req.araddr == `OFS_PORT_B_ANALOG_SELECT
		|=> (axil_rsp.rdata & ~{24'h00_0000, `PORT_B_ANALOG_MASK}) == 32'h0000_0000
	) else $error("port B analog read shows unused bits");

	dir_write_a: assert property ( // R15
		wr.en && wr.strb && wr.addr == `OFS_PORT_B_DIRECTION
		|=> port_b_direction_q == $past(wr.data)
	) else $error("direction write lost");

	// Direction alone decides the driver whatever the analog select holds
	analog_dir_a: assert property ( // R6
		port_b_analog_select_q != 8'h00 && func_req == '0
		|=> pin_oe == ~$past(port_b_direction_q)
	) else $error("direction ignored on analog pins");

	input_live_a: assert property ( // R14
		pin_oe[3] && !port_b_analog_select_q[3]
		|=> digital_in[3] == $past(pin_sample_q[3])
	) else $error("input path lost on a driven pin");

	top_slot_a: assert property ( // R12
		func_req[0][0].en
		|=> pin_oe[0] == $past(func_req[0][0].oe)
		&& pin_out[0] == ($past(func_req[0][0].out) && $past(func_req[0][0].oe))
	) else $error("top slot did not own the pin");

	dead_slot_a: assert property ( // R13
		func_req[4][3].en && !func_req[4][0].en && !func_req[4][1].en && !func_req[4][2].en
		|=> pin_oe[4] == !$past(port_b_direction_q[4])
	) else $error("unused slot claimed a pin");

	pullup_all_a: assert property ( // R19
		mux_oe != 8'h00 |=> (pullup_en & $past(mux_oe)) == 8'h00
	) else $error("pull-up left on for a driven pin");

	analog_b_write_a: assert property ( // R11
		wr.en && wr.strb && wr.addr == `OFS_PORT_B_ANALOG_SELECT
		|=> port_b_analog_select_q == ($past(wr.data) & `PORT_B_ANALOG_MASK)
	) else $error("port B analog write lost");

	pin_write_cov: cover property (
		wr.en && wr.addr == `OFS_PORT_B_PIN_VALUE ##1 axil_rsp.awready
	);
	analog_output_cov: cover property (
		port_b_analog_select_q[0] && !port_b_direction_q[0] ##1 pin_oe[0]
	);
	periph_owns_cov: cover property (
		func_req[0][0].en && func_req[0][1].en ##1 pin_oe[0]
	);
	bad_addr_cov: cover property (
		axil_rsp.rvalid && axil_rsp.rresp == `RESP_SLVERR
	);
endmodule : gpio_port_latch_analog_select

`default_nettype wire

// >>> pin_pad_model.sv
// Pad ring model for port B: resolves each pin level from the block's own
// driver, an outside source and the weak pull-up.
// Assumes the bench enables its outside source only on pins set as inputs.
`timescale 1ns/1ps
`default_nettype none

module pin_pad_model (
	input wire logic aclk,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pullup_en,
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	output logic [7:0] pin_level
);
	logic [7:0] float_q = 8'h55;

	// Undriven pins wander each cycle, so a stale level never passes for a read
	always_ff @(posedge aclk) begin
		float_q <= ~float_q;
	end

	// Block driver first, then the outside source, then the pull-up
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pin_oe[i])
				pin_level[i] = pin_out[i];
			else if (ext_en[i])
				pin_level[i] = ext_val[i];
			else if (pullup_en[i])
				pin_level[i] = 1'b1;
			else
				pin_level[i] = float_q[i];
		end
	end
endmodule : pin_pad_model

`default_nettype wire

// >>> tb.sv
// Self-checking bench for the GPIO port block: AXI4-Lite master tasks,
// pad model on port B and one task per scenario.
// Assumes the package, parameter header, design and pad model compile first.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_params.svh"

module tb;
	import gpio_port_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	axil_req_type req = '0;
	axil_rsp_type rsp;
	pin_func_type [7:0][3:0] func = '0;
	logic [7:0] pin_in, pin_out, pin_oe, pullup_en, digital_in, b_ans, a_lat, a_ans;
	logic [7:0] ext_en = 8'h00;
	logic [7:0] ext_val = 8'h00;
	logic [31:0] rd;
	logic [1:0] resp;
	int bad_count = 0;
	int num_checks = 0;

	always #2 aclk = ~aclk;

	gpio_port_latch_analog_select i_gpio_port_latch_analog_select (.aclk(aclk),
		.aresetn(aresetn), .axil_req(req), .axil_rsp(rsp), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .func_req(func), .pullup_en(pullup_en),
		.digital_in(digital_in), .port_b_analog_bit(b_ans), .port_a_output_latch(a_lat),
		.port_a_analog_bit(a_ans));

	pin_pad_model i_pin_pad_model (.aclk(aclk), .pin_oe(pin_oe), .pin_out(pin_out),
		.pullup_en(pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_in));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// Address and data offered together, each dropped once its ready is seen
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic s = 1'b1);
		@(posedge aclk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= {24'h00_0000, d};
		req.wstrb <= {3'b000, s};
		req.bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (rsp.awready)
				req.awvalid <= 1'b0;
			if (rsp.wready)
				req.wvalid <= 1'b0;
		end while (!rsp.bvalid);
		req.bready <= 1'b0;
		resp = rsp.bresp;
	endtask : wr

	task automatic rd_reg(input logic [7:0] a);
		@(posedge aclk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (rsp.arready)
				req.arvalid <= 1'b0;
		end while (!rsp.rvalid);
		req.rready <= 1'b0;
		rd = rsp.rdata;
		resp = rsp.rresp;
	endtask : rd_reg

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		rd_reg(a);
		check(resp, `RESP_OKAY);
		check(rd, exp);
	endtask : rchk

	// Pin outputs trail a register write by one cycle; three leaves margin
	task automatic settle;
		repeat (3) @(posedge aclk);
		#1;
	endtask : settle

	task automatic drive_ext(input logic [7:0] en, input logic [7:0] val);
		@(posedge aclk);
		ext_en <= en;
		ext_val <= val;
		settle;
	endtask : drive_ext

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		#1;
		check(pin_oe, 8'h00);
		rchk(`OFS_PORT_B_DIRECTION, 32'h0000_00FF);
		rchk(`OFS_PORT_A_ANALOG_SELECT, 32'h0000_002F);
		rchk(`OFS_PORT_B_ANALOG_SELECT, 32'h0000_003F);
		rd_reg(8'h40);
		check(resp, `RESP_SLVERR);
		wr(8'h40, 8'h00);
		check(resp, `RESP_SLVERR);
		$display("test reset done");
	endtask : t_reset

	task automatic t_analog_mask;
		wr(`OFS_PORT_A_ANALOG_SELECT, 8'hFF);
		rchk(`OFS_PORT_A_ANALOG_SELECT, 32'h0000_002F);
		wr(`OFS_PORT_A_ANALOG_SELECT, 8'h00);
		rchk(`OFS_PORT_A_ANALOG_SELECT, 32'h0000_0000);
		wr(`OFS_PORT_B_ANALOG_SELECT, 8'hFF);
		rchk(`OFS_PORT_B_ANALOG_SELECT, 32'h0000_003F);
		check(b_ans, 8'h3F);
		check(a_ans, 8'h00);
		$display("test analog mask done");
	endtask : t_analog_mask

	task automatic t_latch_drive;
		wr(`OFS_PORT_B_ANALOG_SELECT, 8'h00);
		wr(`OFS_PORT_B_PIN_VALUE, 8'hA5);
		wr(`OFS_PORT_B_DIRECTION, 8'h00);
		wr(`OFS_PORT_A_OUTPUT_LATCH, 8'h5A);
		settle;
		check(pin_oe, 8'hFF);
		check(pin_out, 8'hA5);
		check(digital_in, 8'hA5);
		check(a_lat, 8'h5A);
		rchk(`OFS_PORT_B_OUTPUT_LATCH, 32'h0000_00A5);
		rchk(`OFS_PORT_A_OUTPUT_LATCH, 32'h0000_005A);
		rchk(`OFS_PORT_B_PIN_VALUE, 32'h0000_00A5);
		wr(`OFS_PORT_B_DIRECTION, 8'hFF);
		drive_ext(8'hFF, 8'h3C);
		check(pin_oe, 8'h00);
		rchk(`OFS_PORT_B_PIN_VALUE, 32'h0000_003C);
		rchk(`OFS_PORT_B_OUTPUT_LATCH, 32'h0000_00A5);
		$display("test latch drive done");
	endtask : t_latch_drive

	// Analog pins read low, and a read-back write carries that into the latch
	task automatic t_analog_read;
		wr(`OFS_PORT_B_ANALOG_SELECT, 8'hFF);
		drive_ext(8'hFF, 8'hFF);
		rchk(`OFS_PORT_B_PIN_VALUE, 32'h0000_00C0);
		check(digital_in, 8'hC0);
		wr(`OFS_PORT_B_PIN_VALUE, 8'h00, 1'b0);
		rchk(`OFS_PORT_B_OUTPUT_LATCH, 32'h0000_00C0);
		drive_ext(8'h00, 8'h00);
		wr(`OFS_PORT_B_DIRECTION, 8'h00);
		settle;
		check(pin_oe, 8'hFF);
		check(pin_out, 8'hC0);
		$display("test analog read done");
	endtask : t_analog_read

	// Slots s..3 claim the pin, only slot s drives a one; slot 3 is dead on 4-7
	task automatic t_priority;
		wr(`OFS_PORT_B_ANALOG_SELECT, 8'h00);
		wr(`OFS_PORT_B_PIN_VALUE, 8'h00);
		for (int p = 0; p < 8; p++) begin
			for (int s = 0; s < 4; s++) begin
				@(posedge aclk);
				for (int k = 0; k < 4; k++)
					func[p][k] <= {k >= s, 1'b1, k == s};
				settle;
				check(pin_out[p], (s <= ((p < 4) ? 3 : 2)));
				check(pin_oe[p], 1'b1);
			end
			@(posedge aclk);
			func[p] <= '0;
		end
		$display("test priority done");
	endtask : t_priority

	task automatic t_pullup;
		wr(`OFS_PORT_B_PULLUP, 8'hFF);
		wr(`OFS_PULLUP_CONTROL, 8'h00);
		wr(`OFS_PORT_B_DIRECTION, 8'h0F);
		settle;
		check(pullup_en, 8'h0F);
		rchk(`OFS_PORT_B_PIN_VALUE, 32'h0000_000F);
		$display("test pullup done");
	endtask : t_pullup

	task automatic t_warm_reset;
		wr(`OFS_PORT_B_OUTPUT_LATCH, 8'h69);
		wr(`OFS_PORT_B_DIRECTION, 8'h00);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		settle;
		check(pin_oe, 8'h00);
		rchk(`OFS_PORT_B_DIRECTION, 32'h0000_00FF);
		rchk(`OFS_PORT_B_OUTPUT_LATCH, 32'h0000_0069);
		rchk(`OFS_PORT_A_OUTPUT_LATCH, 32'h0000_005A);
		rchk(`OFS_PORT_B_ANALOG_SELECT, 32'h0000_003F);
		$display("test warm reset done");
	endtask : t_warm_reset

	// ----------------------------------------
	// Run control
	// ----------------------------------------
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset;
		t_analog_mask;
		t_latch_drive;
		t_analog_read;
		t_priority;
		t_pullup;
		t_warm_reset;
		complete_run;
	end

	// The whole run needs well under a thousand cycles; this cuts a hang
	initial begin
		repeat (5000) @(posedge aclk);
		bad_count++;
		complete_run;
	end
endmodule : tb

`default_nettype wire
